// ===== host_if_cfg.svh
`ifndef HOST_IF_CFG_SVH
`define HOST_IF_CFG_SVH

`define CLK_HZ 125000000
`define DATA_BAUD 9600
`define DATA_W 8
`define PWM_W 16
`define IO_N 4
`define TMO_W 24
`define BAUD_W 16
`define FRAME_BITS 4'h9
`define LINE_IDLE 1'h1

`endif

// ===== host_if_pkg.sv
`default_nettype none
`include "host_if_cfg.svh"

package host_if_pkg;

    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [0:0] {PWR_ASLEEP, PWR_AWAKE} pwr_state_t;

    typedef struct packed {
        tx_state_t st;
        logic [`DATA_W:0] sh;
        logic [3:0] n;
        logic txd;
        logic accept;
        logic busy;
    } tx_regs_t;

    typedef struct packed {
        logic rts_s1;
        logic rts_s2;
        logic wake_s1;
        logic wake_s2;
        logic rxd_s1;
        logic rxd_s2;
        logic sclk_s1;
        logic sclk_s2;
        logic mosi_s1;
        logic mosi_s2;
        logic miso_s1;
        logic miso_s2;
        logic ss_s1;
        logic ss_s2;
        logic [`IO_N-1:0] io_s1;
        logic [`IO_N-1:0] io_s2;
        logic [`BAUD_W-1:0] baud_cnt;
        logic baud_tick;
        pwr_state_t pwr;
        logic [`TMO_W-1:0] tmo_cnt;
        logic awake;
        logic ready_n;
        logic [`PWM_W-1:0] pwm_cnt;
        logic pwm_out;
        logic miso_o;
        logic miso_oe;
        logic mosi_o;
        logic mosi_oe;
        logic ss_n_o;
        logic ss_n_oe;
        logic sclk_o;
        logic sclk_oe;
        logic [`IO_N-1:0] io_o;
        logic [`IO_N-1:0] io_oe;
        logic [`IO_N-1:0] io_pu;
    } if_regs_t;

endpackage

`default_nettype wire

// ===== serial_char_tx.sv
`default_nettype none
`include "host_if_cfg.svh"

module serial_char_tx (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic baud_tick,
    input wire logic permit,
    input wire logic [`DATA_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_accept,
    output logic txd,
    output logic busy
);
    host_if_pkg::tx_regs_t r_r;
    host_if_pkg::tx_regs_t r_nxt;

    always_comb begin
        r_nxt = r_r;
        r_nxt.accept = 1'h0;
        case (r_r.st)
            host_if_pkg::TX_IDLE: begin
                r_nxt.txd = `LINE_IDLE;
                // permit looked at only here, so a started character always finishes
                if (baud_tick && tx_valid && permit) begin // [R4] [R16]
                    r_nxt.txd = 1'h0;
                    r_nxt.sh = {`LINE_IDLE, tx_data};
                    r_nxt.n = `FRAME_BITS;
                    r_nxt.st = host_if_pkg::TX_SHIFT;
                    r_nxt.accept = 1'h1;
                    r_nxt.busy = 1'h1;
                end
            end
            host_if_pkg::TX_SHIFT: begin
                if (baud_tick) begin
                    if (r_r.n == 4'h0) begin
                        r_nxt.st = host_if_pkg::TX_IDLE;
                        r_nxt.busy = 1'h0;
                    end else begin
                        r_nxt.txd = r_r.sh[0];
                        r_nxt.sh = {1'h0, r_r.sh[`DATA_W:1]};
                        r_nxt.n = r_r.n - 4'h1;
                    end
                end
            end
            default: begin
                r_nxt.st = host_if_pkg::TX_IDLE;
                r_nxt.txd = `LINE_IDLE;
                r_nxt.busy = 1'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r_r <= '0;
            r_r.txd <= `LINE_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign tx_accept = r_r.accept;
    assign txd = r_r.txd;
    assign busy = r_r.busy;

    sequence s_start;
        r_r.st == host_if_pkg::TX_IDLE && baud_tick && tx_valid && permit;
    endsequence

    sequence s_denied;
        r_r.st == host_if_pkg::TX_IDLE && !permit;
    endsequence

    a_start_bit_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
        s_start |=> !txd && busy && tx_accept)
        else $error("character start did not drive start bit");

    a_denied_no_start: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        s_denied |=> !busy && txd)
        else $error("character started while host denied");

endmodule

`default_nettype wire

// ===== host_flow_wake_interface.sv
// Function
// R1 - ready output low only when room exists
// R2 - host stops sending while ready high
// R3 - host holds permit low to receive
// R4 - stop serial output while permit high
// R5 - wake input high wakes from sleep
// R6 - awake output rises on leaving sleep
// R7 - low reset input holds device reset
// R8 - miso input as master, output slave
// R9 - mosi output as master, input slave
// R10 - active-low select: master drives, slave samples
// R11 - spi clock output master, input slave
// R12 - pull-up on io line when input
// R13 - pwm output has sixteen-bit resolution
// R14 - awake output stays high while awake
// R15 - timeout timer held during activity conditions
// R16 - check permit before each character, finish current
`default_nettype none
`include "host_if_cfg.svh"

module host_flow_wake_interface #(
    parameter int BAUD_DIV = `CLK_HZ / `DATA_BAUD
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [`DATA_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_accept,
    output logic radio_txd,
    input wire logic permit_n,
    input wire logic radio_rxd,
    output logic rx_line,
    input wire logic rx_space,
    output logic host_ready_n,
    input wire logic wake_in,
    input wire logic autoreport_fire,
    input wire logic rf_busy,
    input wire logic commissioned,
    input wire logic [`TMO_W-1:0] wake_timeout,
    output logic awake_out,
    input wire logic spi_master,
    input wire logic m_sclk,
    input wire logic m_mosi,
    input wire logic m_ss_n,
    input wire logic s_miso,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe,
    output logic spi_sclk_in,
    output logic spi_mosi_in,
    output logic spi_miso_in,
    output logic spi_ss_n_in,
    input wire logic [`IO_N-1:0] io_dir,
    input wire logic [`IO_N-1:0] io_out,
    input wire logic [`IO_N-1:0] config_io_line_in,
    output logic [`IO_N-1:0] config_io_line_out,
    output logic [`IO_N-1:0] config_io_line_oe,
    output logic [`IO_N-1:0] config_io_line_pullup,
    output logic [`IO_N-1:0] io_val,
    input wire logic [`PWM_W-1:0] pwm_duty,
    output logic pulse_width_out_zero
);
    host_if_pkg::if_regs_t r_r;
    host_if_pkg::if_regs_t r_nxt;
    logic timer_hold;
    logic tx_busy;

    // start bit on the data input counts as serial data arriving
    assign timer_hold = r_r.wake_s2 || !r_r.rxd_s2 || rf_busy || !commissioned; // [R15]

    always_comb begin
        r_nxt = r_r;
        r_nxt.rts_s1 = permit_n;
        r_nxt.rts_s2 = r_r.rts_s1;
        r_nxt.wake_s1 = wake_in;
        r_nxt.wake_s2 = r_r.wake_s1;
        r_nxt.rxd_s1 = radio_rxd;
        r_nxt.rxd_s2 = r_r.rxd_s1;
        r_nxt.sclk_s1 = sclk_i;
        r_nxt.sclk_s2 = r_r.sclk_s1;
        r_nxt.mosi_s1 = mosi_i;
        r_nxt.mosi_s2 = r_r.mosi_s1;
        r_nxt.miso_s1 = miso_i;
        r_nxt.miso_s2 = r_r.miso_s1;
        r_nxt.ss_s1 = ss_n_i;
        r_nxt.ss_s2 = r_r.ss_s1;
        r_nxt.io_s1 = config_io_line_in;
        r_nxt.io_s2 = r_r.io_s1;

        r_nxt.baud_tick = 1'h0;
        if (r_r.baud_cnt == `BAUD_W'(BAUD_DIV - 1)) begin
            r_nxt.baud_cnt = '0;
            r_nxt.baud_tick = 1'h1;
        end else begin
            r_nxt.baud_cnt = r_r.baud_cnt + `BAUD_W'(1);
        end

        // host must stop once this goes high; no buffer beyond rx_space
        r_nxt.ready_n = !rx_space; // [R1] [R2]

        case (r_r.pwr)
            host_if_pkg::PWR_ASLEEP: begin
                if (r_r.wake_s2 || autoreport_fire) begin // [R5]
                    r_nxt.pwr = host_if_pkg::PWR_AWAKE;
                    r_nxt.tmo_cnt = '0;
                end
            end
            host_if_pkg::PWR_AWAKE: begin
                if (timer_hold) begin
                    r_nxt.tmo_cnt = '0; // [R15]
                end else if (r_r.tmo_cnt >= wake_timeout) begin
                    r_nxt.pwr = host_if_pkg::PWR_ASLEEP;
                end else begin
                    r_nxt.tmo_cnt = r_r.tmo_cnt + `TMO_W'(1);
                end
            end
            default: begin
                r_nxt.pwr = host_if_pkg::PWR_ASLEEP;
            end
        endcase
        r_nxt.awake = (r_nxt.pwr == host_if_pkg::PWR_AWAKE); // [R6] [R14]

        // full 16-bit counter gives 65536 duty steps
        r_nxt.pwm_cnt = r_r.pwm_cnt + `PWM_W'(1); // [R13]
        r_nxt.pwm_out = (r_r.pwm_cnt < pwm_duty); // [R13]

        r_nxt.miso_oe = !spi_master; // [R8]
        r_nxt.miso_o = s_miso;
        r_nxt.mosi_oe = spi_master; // [R9]
        r_nxt.mosi_o = m_mosi;
        r_nxt.ss_n_oe = spi_master; // [R10]
        r_nxt.ss_n_o = m_ss_n;
        r_nxt.sclk_oe = spi_master; // [R11]
        r_nxt.sclk_o = m_sclk;

        r_nxt.io_oe = io_dir;
        r_nxt.io_o = io_out;
        r_nxt.io_pu = ~io_dir; // [R12]
    end

    // reset pin is the block reset; everything parks while it is low
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin // [R7]
            r_r <= '0;
            r_r.rts_s1 <= 1'h1;
            r_r.rts_s2 <= 1'h1;
            r_r.rxd_s1 <= `LINE_IDLE;
            r_r.rxd_s2 <= `LINE_IDLE;
            r_r.ss_s1 <= 1'h1;
            r_r.ss_s2 <= 1'h1;
            r_r.ready_n <= 1'h1;
            r_r.ss_n_o <= 1'h1;
            r_r.io_pu <= '1;
        end else begin
            r_r <= r_nxt;
        end
    end

    serial_char_tx u_tx (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .baud_tick(r_r.baud_tick),
        .permit(!r_r.rts_s2), // [R3] [R4]
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_accept(tx_accept),
        .txd(radio_txd),
        .busy(tx_busy)
    );

    assign rx_line = r_r.rxd_s2;
    assign host_ready_n = r_r.ready_n;
    assign awake_out = r_r.awake;
    assign miso_o = r_r.miso_o;
    assign miso_oe = r_r.miso_oe;
    assign mosi_o = r_r.mosi_o;
    assign mosi_oe = r_r.mosi_oe;
    assign ss_n_o = r_r.ss_n_o;
    assign ss_n_oe = r_r.ss_n_oe;
    assign sclk_o = r_r.sclk_o;
    assign sclk_oe = r_r.sclk_oe;
    assign spi_sclk_in = r_r.sclk_s2;
    assign spi_mosi_in = r_r.mosi_s2;
    assign spi_miso_in = r_r.miso_s2;
    assign spi_ss_n_in = r_r.ss_s2;
    assign config_io_line_out = r_r.io_o;
    assign config_io_line_oe = r_r.io_oe;
    assign config_io_line_pullup = r_r.io_pu;
    assign io_val = r_r.io_s2;
    assign pulse_width_out_zero = r_r.pwm_out;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_sleep_wake;
        !awake_out && wake_in ##2 1'h1;
    endsequence

    a_ready_follows_space: assert property ( // [R1]
        1'h1 |=> host_ready_n == $past(!rx_space))
        else $error("ready output does not follow buffer room");
    a_wake_pin_wakes: assert property ( // [R5] [R6]
        s_sleep_wake |-> ##[1:2] awake_out)
        else $error("wake input did not raise awake output");
    a_awake_held: assert property ( // [R14]
        awake_out && timer_hold |=> awake_out)
        else $error("awake output dropped while held awake");
    a_timer_cleared: assert property ( // [R15]
        awake_out && timer_hold |=> r_r.tmo_cnt == '0)
        else $error("wake timer ran during activity");
    a_reset_parks: assert property (disable iff (1'h0) // [R7]
        !rst_n |=> host_ready_n && !awake_out && !tx_busy && radio_txd)
        else $error("outputs not parked in reset");
    a_master_dirs: assert property ( // [R8] [R9]
        spi_master |=> mosi_oe && !miso_oe)
        else $error("master data pin directions wrong");
    a_slave_dirs: assert property ( // [R10] [R11]
        !spi_master |=> !ss_n_oe && !sclk_oe && miso_oe)
        else $error("slave select or clock driven as slave");
    a_pullup_input: assert property ( // [R12]
        ##1 (config_io_line_pullup == ~config_io_line_oe))
        else $error("pull-up not tied to input direction");
    a_pwm_low_cmp: assert property ( // [R13]
        r_r.pwm_cnt == '1 |=> !pulse_width_out_zero)
        else $error("pwm high at full count");
    a_halt_denied: assert property ( // [R4]
        r_r.rts_s2 && !tx_busy |=> !tx_busy)
        else $error("character started while permit high");

endmodule

`default_nettype wire

// ===== host_model.sv
`default_nettype none
module host_model #(
    parameter int B = 4
) (
    input wire logic ref_clk,
    input wire logic radio_txd,
    input wire logic host_ready_n,
    input wire logic willing,
    output logic permit_n,
    output logic radio_rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_byte;
    int rx_cnt;

    assign permit_n = !willing;

    // samples mid-bit, so edge races at the bit boundary do not matter
    initial begin
        radio_rxd = 1'b1;
        rx_byte = 8'h00;
        rx_cnt = 0;
        forever begin
            @(negedge radio_txd);
            repeat (B + B / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                rx_byte[i] = radio_txd;
                repeat (B) @(posedge ref_clk);
            end
            rx_cnt++;
        end
    end

    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int w = 0; w < 1000 && host_ready_n !== 1'b0; w++) @(negedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            radio_rxd = f[i];
            repeat (B) @(negedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int B = 4;
    localparam int TMO = 20;
    logic ref_clk = 1'b0;
    logic rst_n, tx_valid, tx_accept, radio_txd, permit_n, radio_rxd, rx_line, rx_space;
    logic host_ready_n, wake_in, rf_busy, awake_out, willing, spi_master, m_sclk, m_mosi;
    logic m_ss_n, s_miso, miso_o, miso_oe, mosi_o, mosi_oe, ss_n_o, ss_n_oe, sclk_o, sclk_oe;
    logic spi_sclk_in, spi_mosi_in, spi_miso_in, spi_ss_n_in, pulse_width_out_zero;
    logic [7:0] tx_data;
    logic [3:0] io_dir, io_out, io_val, h_io, config_io_line_out, config_io_line_oe;
    logic [3:0] config_io_line_pullup;
    logic autoreport_fire, commissioned;
    logic [15:0] pwm_duty;
    int n_errors = 0;
    int checks_done = 0;
    // host side of the shared pins: it drives only what the block leaves undriven
    wire logic miso_i = miso_oe ? miso_o : 1'b1;
    wire logic mosi_i = mosi_oe ? mosi_o : 1'b1;
    wire logic ss_n_i = ss_n_oe ? ss_n_o : 1'b0;
    wire logic sclk_i = sclk_oe ? sclk_o : 1'b0;
    wire logic [3:0] io_pin = (config_io_line_oe & config_io_line_out)
        | (~config_io_line_oe & h_io);

    host_flow_wake_interface #(.BAUD_DIV(B)) dut (
        .ref_clk, .rst_n, .tx_data, .tx_valid, .tx_accept, .radio_txd, .permit_n, .radio_rxd,
        .rx_line, .rx_space, .host_ready_n, .wake_in, .autoreport_fire, .rf_busy,
        .commissioned, .wake_timeout(24'(TMO)), .awake_out, .spi_master, .m_sclk,
        .m_mosi, .m_ss_n, .s_miso, .miso_i, .miso_o, .miso_oe, .mosi_i, .mosi_o, .mosi_oe,
        .ss_n_i, .ss_n_o, .ss_n_oe, .sclk_i, .sclk_o, .sclk_oe, .spi_sclk_in, .spi_mosi_in,
        .spi_miso_in, .spi_ss_n_in, .io_dir, .io_out, .config_io_line_in(io_pin),
        .config_io_line_out, .config_io_line_oe, .config_io_line_pullup, .io_val, .pwm_duty,
        .pulse_width_out_zero
    );
    host_model #(.B(B)) host (
        .ref_clk, .radio_txd, .host_ready_n, .willing, .permit_n, .radio_rxd
    );

    always #4 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic lim(input int w);
        if (w >= 400) begin
            n_errors++;
            results();
        end
    endtask

    task automatic wait_acc();
        int w;
        for (w = 0; w < 400 && tx_accept !== 1'b1; w++) @(negedge ref_clk);
        lim(w);
    endtask

    task automatic wait_rx(input int c);
        int w;
        for (w = 0; w < 400 && host.rx_cnt == c; w++) @(negedge ref_clk);
        lim(w);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk({host_ready_n, awake_out, radio_txd, tx_accept}, 4'ha);
        chk({config_io_line_oe, config_io_line_pullup, sclk_oe, mosi_oe, ss_n_oe, miso_oe},
            12'h0f0);
        rst_n = 1'b1;
        @(negedge ref_clk);
    endtask

    task automatic stay(input int k, input logic v);
        int w;
        w = 0;
        repeat (k) begin
            @(negedge ref_clk);
            w += (awake_out !== v);
        end
        chk(w, 0);
    endtask

    task automatic t_wake();
        int n;
        n = 0;
        wake_in = 1'b1;
        while (n < 9 && awake_out !== 1'b1) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, 3);
        stay(50, 1'b1);
        rf_busy = 1'b1;
        wake_in = 1'b0;
        stay(TMO, 1'b1);
        rf_busy = 1'b0;
        commissioned = 1'b0;
        stay(2 * TMO, 1'b1);
        commissioned = 1'b1;
        n = 0;
        while (n < 4 * TMO && awake_out === 1'b1) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n >= TMO && n <= TMO + 4, 1'b1);
        stay(30, 1'b0);
        autoreport_fire = 1'b1;
        @(negedge ref_clk);
        autoreport_fire = 1'b0;
        chk(awake_out, 1'b1);
        wake_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        wake_in = 1'b0;
        do_reset();
    endtask

    task automatic t_flow();
        int lo;
        lo = 0;
        rx_space = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(host_ready_n, 1'b1);
        fork
            host.send(8'h96);
            begin
                repeat (40) @(negedge ref_clk);
                chk(rx_line, 1'b1);
                rx_space = 1'b1;
                repeat (2) @(negedge ref_clk);
                chk(host_ready_n, 1'b0);
                repeat (12 * B) begin
                    @(negedge ref_clk);
                    lo += (rx_line === 1'b0);
                end
            end
        join
        chk(lo, 5 * B);
    endtask

    task automatic t_tx();
        int w;
        int c;
        w = 0;
        c = host.rx_cnt;
        willing = 1'b0;
        // permit passes two sync stages before the block sees it
        repeat (3) @(negedge ref_clk);
        tx_data = 8'ha5;
        tx_valid = 1'b1;
        repeat (60) begin
            @(negedge ref_clk);
            w += (tx_accept !== 1'b0) || (radio_txd !== 1'b1);
        end
        chk(w, 0);
        willing = 1'b1;
        wait_acc();
        tx_valid = 1'b0;
        willing = 1'b0;
        @(negedge ref_clk);
        tx_data = 8'h3c;
        tx_valid = 1'b1;
        wait_rx(c);
        chk(host.rx_byte, 8'ha5);
        repeat (60) begin
            @(negedge ref_clk);
            w += (tx_accept !== 1'b0);
        end
        chk(w, 0);
        willing = 1'b1;
        wait_acc();
        tx_valid = 1'b0;
        wait_rx(c + 1);
        chk(host.rx_byte, 8'h3c);
    endtask

    task automatic t_spi();
        for (int m = 0; m < 2; m++) begin
            spi_master = m[0];
            io_dir = m[0] ? 4'h5 : 4'ha;
            repeat (4) @(negedge ref_clk);
            chk({sclk_oe, mosi_oe, ss_n_oe, miso_oe}, m[0] ? 4'he : 4'h1);
            chk({sclk_i, mosi_i, ss_n_i, miso_i}, m[0] ? 4'hd : 4'h5);
            chk({spi_sclk_in, spi_mosi_in, spi_ss_n_in, spi_miso_in}, m[0] ? 4'hd : 4'h5);
            chk(config_io_line_pullup, 4'(~io_dir));
            chk(io_val, (io_dir & io_out) | (~io_dir & h_io));
        end
    endtask

    task automatic t_pwm();
        int h;
        h = 0;
        pwm_duty = 16'h1234;
        repeat (4) @(negedge ref_clk);
        repeat (65536) begin
            @(negedge ref_clk);
            h += (pulse_width_out_zero === 1'b1);
        end
        chk(h, 32'h0000_1234);
    endtask

    initial begin
        rst_n = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_space = 1'b1;
        wake_in = 1'b0;
        rf_busy = 1'b0;
        willing = 1'b1;
        spi_master = 1'b0;
        m_sclk = 1'b1;
        m_mosi = 1'b1;
        m_ss_n = 1'b0;
        s_miso = 1'b1;
        autoreport_fire = 1'b0;
        commissioned = 1'b1;
        io_dir = 4'h0;
        io_out = 4'h9;
        h_io = 4'h6;
        pwm_duty = 16'h0000;
        do_reset();
        t_wake();
        t_flow();
        t_tx();
        t_spi();
        t_pwm();
        results();
    end
endmodule
`default_nettype wire
